// ===== inc/fp_load_address_gen_defines.svh
/*
 * Offsets, field positions, reset values and opcode codes for the floating-point
 * load/store address generator. Assumes a 32-bit instruction word, MSB-0 field
 * numbering mapped onto little-endian vector bits (bit 31 of the word is bit 0 here).
 */
`ifndef FP_LOAD_ADDRESS_GEN_DEFINES_SVH
`define FP_LOAD_ADDRESS_GEN_DEFINES_SVH

// Wishbone register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_MASK        8'h08
`define REG_LAST_EA     8'h0c
`define REG_COUNT       8'h10

// Control register fields
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_VAL  32'h0000_0001

// Status / mask bit positions
`define EV_DONE_BIT     0
`define EV_INVALID_BIT  1
`define EV_ALIGN_BIT    2
`define EV_WIDTH        3

// Instruction word fields (vector bit positions)
`define OPC_HI          31
`define OPC_LO          26
`define TGT_HI          25
`define TGT_LO          21
`define BASE_HI         20
`define BASE_LO         16
`define IDX_HI          15
`define IDX_LO          11
`define XO_HI           10
`define XO_LO           1
`define CRU_BIT         0

// Primary opcodes of the immediate forms and of the indexed forms
`define OP_SINGLE       6'h30
`define OP_SINGLE_UPD   6'h31
`define OP_DOUBLE       6'h32
`define OP_DOUBLE_UPD   6'h33
`define OP_EXT          6'h1f
// Extended opcodes of the indexed forms
`define XO_SINGLE       10'h217
`define XO_SINGLE_UPD   10'h237
`define XO_DOUBLE       10'h257
`define XO_DOUBLE_UPD   10'h277

// Single-to-double exponent rebias (1023 - 127)
`define EXP_REBIAS      11'h380

`endif

// ===== inc/fp_load_address_gen_pkg.sv
/*
 * Types shared by the floating-point load address generator.
 * Assumes the defines header is compiled alongside.
 */
`default_nettype none

package fp_load_address_gen_pkg;

	// Decoded load variant
	typedef struct packed {
		logic valid;
		logic isDouble;
		logic isIndexed;
		logic isUpdate;
		logic invalidForm;
	} load_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MEM,
		ST_WRITE
	} load_state_t;

endpackage : fp_load_address_gen_pkg

`default_nettype wire

// ===== src/fp_ea_adder.sv
/*
 * Effective-address adder: (base|0) + displacement or index.
 * Assumes the operands arrive already read from the integer register file.
 */
`default_nettype none

module fp_ea_adder #(
	parameter int ADDR_W = 32
) (
	// Operands
	input  wire logic [ADDR_W-1:0] baseVal,
	input  wire logic              baseIsZeroField,
	input  wire logic              forceBase,
	input  wire logic [ADDR_W-1:0] indexVal,
	input  wire logic [15:0]       disp,
	input  wire logic              indexed,
	// Result
	output logic      [ADDR_W-1:0] ea
);
	logic [ADDR_W-1:0] baseUse;
	logic [ADDR_W-1:0] addend;

	initial begin
		if (ADDR_W < 16) $error("ADDR_W must be at least 16");
	end

	// Field zero reads as zero unless an update form forces the register
	assign baseUse = (baseIsZeroField && !forceBase) ? '0 : baseVal;
	// Displacement sign extension to the address width
	assign addend  = indexed ? indexVal
	                         : {{(ADDR_W-16){disp[15]}}, disp};
	assign ea      = baseUse + addend;
endmodule : fp_ea_adder

`default_nettype wire

// ===== src/fp_single_to_double.sv
/*
 * Single-precision to double-precision format conversion for load data.
 * Assumes IEEE layouts; denormal singles are normalised with a leading-zero count.
 */
`default_nettype none

`include "fp_load_address_gen_defines.svh"

module fp_single_to_double (
	// Single operand in
	input  wire logic [31:0] single,
	// Double result out
	output logic      [63:0] double
);
	logic [7:0]  exp8;
	logic [22:0] frac;
	logic [4:0]  lz;
	logic        found;
	logic [22:0] normFrac;
	logic [10:0] normExp;

	assign exp8 = single[30:23];
	assign frac = single[22:0];

	// Leading-zero count for denormal inputs
	always_comb begin
		lz    = 5'h00;
		found = 1'b0;
		for (int i = 22; i >= 0; i--) begin
			if (!found && frac[i]) begin
				lz    = 5'(22 - i);
				found = 1'b1;
			end
		end
	end

	assign normFrac = 23'(frac << (lz + 5'h01));
	assign normExp  = 11'(`EXP_REBIAS + 11'h001 - 11'h001 - {6'h00, lz});

	// Zero, inf/NaN, normal and denormal each map differently
	always_comb begin
		if (exp8 == 8'hff) begin
			double = {single[31], 11'h7ff, frac, 29'h0};
		end else if (exp8 != 8'h00) begin
			double = {single[31], 11'({3'h0, exp8}) + `EXP_REBIAS, frac, 29'h0};
		end else if (frac == 23'h0) begin
			double = {single[31], 63'h0};
		end else begin
			double = {single[31], normExp, normFrac, 29'h0};
		end
	end
endmodule : fp_single_to_double

`default_nettype wire

// ===== src/fp_load_address_gen.sv
/*
 * Floating-point load/store address generation and load execution, with a
 * classic Wishbone register slave for control, events and statistics.
 * Assumes the issuing pipeline holds the instruction until accepted, the integer
 * register file answers reads combinationally and the memory path answers with
 * a one-cycle done pulse carrying the double word.
 */
// What this block does
// - Addresses are formed only as base plus displacement or base plus index.
// - An access to a direct-store segment is not performed and raises an alignment exception.
// - The 16-bit displacement is sign-extended and added to the base.
// - In the immediate form a base field of zero uses zero as base.
// - The indexed form adds the base and index register contents.
// - In the indexed form a base field of zero adds zero to the index.
// - An indexed-form encoding with the condition-update bit set is an invalid form.
// - The underflow-enable status bit never steers store denormalisation.
// - Single load data is converted to double before reaching the target register.
// - A load-with-update whose base field is zero is an invalid form.
// - Single loads read a word, convert it and write the target register.
// - Double loads write the double word unchanged to the target register.
// - Update loads always use the base contents and write the address back to it.
`default_nettype none

`include "fp_load_address_gen_defines.svh"

module fp_load_address_gen
	import fp_load_address_gen_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Instruction issue
	input  wire logic              issueValid,
	input  wire logic [31:0]       issueInstr,
	input  wire logic              directStore,
	input  wire logic              underflowEnable,
	output logic                   issueReady,
	// Integer register file read/write
	output logic      [4:0]        baseRegSel,
	output logic      [4:0]        indexRegSel,
	input  wire logic [ADDR_W-1:0] baseRegVal,
	input  wire logic [ADDR_W-1:0] indexRegVal,
	output logic                   intWrEn,
	output logic      [4:0]        intWrSel,
	output logic      [ADDR_W-1:0] intWrData,
	// Memory access path
	output logic                   memReq,
	output logic      [ADDR_W-1:0] memAddr,
	output logic                   memDouble,
	input  wire logic              memDone,
	input  wire logic [63:0]       memData,
	// Floating-point register file write
	output logic                   fpWrEn,
	output logic      [4:0]        fpTarget,
	output logic      [63:0]       fpWrData,
	// Exceptions and interrupt
	output logic                   invalidForm,
	output logic                   alignException,
	output logic                   irq
);

	initial begin
		if (ADDR_W != 32 && ADDR_W != 64) $error("ADDR_W must be 32 or 64");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		load_state_t            state;
		logic [31:0]            instr;
		load_kind_t             kind;
		logic [ADDR_W-1:0]      ea;
		logic [63:0]            data;
		logic                   enable;
		logic [`EV_WIDTH-1:0]   status;
		logic [`EV_WIDTH-1:0]   mask;
		logic [31:0]            count;
		logic                   ack;
		logic [31:0]            rdata;
		logic                   invalid;
		logic                   align;
	} state_t;

	state_t cur_q;
	state_t nxt_d;

	load_kind_t  decoded;
	logic [5:0]  opc;
	logic [9:0]  xo;
	logic [4:0]  baseField;
	logic [ADDR_W-1:0] eaNow;
	logic [63:0] convData;
	logic        wbReq;
	logic [`EV_WIDTH-1:0] evSet;
	logic [31:0] wMask;

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	assign opc       = issueInstr[`OPC_HI:`OPC_LO];
	assign xo        = issueInstr[`XO_HI:`XO_LO];
	assign baseField = issueInstr[`BASE_HI:`BASE_LO];

	// Eight load variants from primary and extended opcodes
	always_comb begin
		decoded = '0;
		case (opc)
			`OP_SINGLE:     decoded.valid = 1'b1;
			`OP_SINGLE_UPD: begin
				decoded.valid    = 1'b1;
				decoded.isUpdate = 1'b1;
			end
			`OP_DOUBLE:     begin
				decoded.valid    = 1'b1;
				decoded.isDouble = 1'b1;
			end
			`OP_DOUBLE_UPD: begin
				decoded.valid    = 1'b1;
				decoded.isDouble = 1'b1;
				decoded.isUpdate = 1'b1;
			end
			`OP_EXT: begin
				decoded.isIndexed = 1'b1;
				decoded.valid     = (xo == `XO_SINGLE) || (xo == `XO_SINGLE_UPD)
				                 || (xo == `XO_DOUBLE) || (xo == `XO_DOUBLE_UPD);
				decoded.isDouble  = (xo == `XO_DOUBLE) || (xo == `XO_DOUBLE_UPD);
				decoded.isUpdate  = (xo == `XO_SINGLE_UPD) || (xo == `XO_DOUBLE_UPD);
				// The condition-update bit is vector bit 0, just below the xo field, in X-form only
				decoded.invalidForm = issueInstr[`CRU_BIT];
			end
			default: decoded = '0;
		endcase
		if (decoded.isUpdate && baseField == 5'h00) begin
			decoded.invalidForm = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Datapath

	assign baseRegSel  = baseField;
	assign indexRegSel = issueInstr[`IDX_HI:`IDX_LO];

	fp_ea_adder #(
		.ADDR_W (ADDR_W)
	) u_adder (
		.baseVal         (baseRegVal),
		.baseIsZeroField (baseField == 5'h00),
		.forceBase       (decoded.isUpdate),
		.indexVal        (indexRegVal),
		.disp            (issueInstr[15:0]),
		.indexed         (decoded.isIndexed),
		.ea              (eaNow)
	);

	fp_single_to_double u_conv (
		.single (memData[31:0]),
		.double (convData)
	);

	assign wbReq = wb_cyc_i && wb_stb_i && !cur_q.ack;
	assign wMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_d         = cur_q;
		evSet         = '0;
		nxt_d.invalid = 1'b0;
		nxt_d.align   = 1'b0;
		nxt_d.ack     = 1'b0;
		case (cur_q.state)
			ST_IDLE: begin
				if (issueValid && cur_q.enable) begin
					nxt_d.instr = issueInstr;
					nxt_d.kind  = decoded;
					nxt_d.ea    = eaNow;
					// Underflow enable is deliberately unread here
					if (!decoded.valid || decoded.invalidForm) begin
						nxt_d.invalid              = 1'b1;
						evSet[`EV_INVALID_BIT]     = 1'b1;
					end else if (directStore) begin
						nxt_d.align                = 1'b1;
						evSet[`EV_ALIGN_BIT]       = 1'b1;
					end else begin
						nxt_d.state = ST_MEM;
					end
				end
			end
			ST_MEM: begin
				if (memDone) begin
					// Single data converted, double passed through unchanged
					nxt_d.data  = cur_q.kind.isDouble ? memData
					                                  : convData;
					nxt_d.state = ST_WRITE;
				end
			end
			ST_WRITE: begin
				nxt_d.state         = ST_IDLE;
				nxt_d.count         = cur_q.count + 32'h1;
				evSet[`EV_DONE_BIT] = 1'b1;
			end
			default: nxt_d.state = ST_IDLE;
		endcase

		// Register slave, single-cycle answer; reads see pre-write state
		if (wbReq) begin
			nxt_d.ack = 1'b1;
			case (wb_adr_i)
				`REG_CTRL:    nxt_d.rdata = {31'h0, cur_q.enable};
				`REG_STATUS:  nxt_d.rdata = {29'h0, cur_q.status};
				`REG_MASK:    nxt_d.rdata = {29'h0, cur_q.mask};
				`REG_LAST_EA: nxt_d.rdata = 32'(cur_q.ea);
				`REG_COUNT:   nxt_d.rdata = cur_q.count;
				default:      nxt_d.rdata = 32'h0;
			endcase
			if (wb_we_i) begin
				case (wb_adr_i)
					`REG_CTRL: if (wb_sel_i[0]) nxt_d.enable = wb_dat_i[`CTRL_ENABLE_BIT];
					`REG_STATUS: nxt_d.status = cur_q.status & ~wMask[`EV_WIDTH-1:0]
					                          & ~wb_dat_i[`EV_WIDTH-1:0] | cur_q.status
					                          & ~(wMask[`EV_WIDTH-1:0] & wb_dat_i[`EV_WIDTH-1:0]);
					`REG_MASK: if (wb_sel_i[0]) nxt_d.mask = wb_dat_i[`EV_WIDTH-1:0];
					`REG_COUNT: if (wb_sel_i != 4'h0) nxt_d.count = 32'h0;
					default: ;
				endcase
			end
		end
		// New events win over a clear in the same cycle
		nxt_d.status = nxt_d.status | evSet;
	end

	// Single register stage for the whole state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur_q        <= '0;
			cur_q.state  <= ST_IDLE;
			cur_q.enable <= 1'b1;
		end else begin
			cur_q <= nxt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign issueReady     = (cur_q.state == ST_IDLE) && cur_q.enable;
	assign memReq         = (cur_q.state == ST_MEM);
	assign memAddr        = cur_q.ea;
	assign memDouble      = cur_q.kind.isDouble;
	assign fpWrEn         = (cur_q.state == ST_WRITE);
	assign fpTarget       = cur_q.instr[`TGT_HI:`TGT_LO];
	assign fpWrData       = cur_q.data;
	// Address write-back for update forms, same cycle as the target write
	assign intWrEn        = (cur_q.state == ST_WRITE) && cur_q.kind.isUpdate;
	assign intWrSel       = cur_q.instr[`BASE_HI:`BASE_LO];
	assign intWrData      = cur_q.ea;
	assign invalidForm    = cur_q.invalid;
	assign alignException = cur_q.align;
	assign wb_ack_o       = cur_q.ack;
	assign wb_dat_o       = cur_q.rdata;
	assign irq            = |(cur_q.status & cur_q.mask);

	// Store denormalisation never looks at underflow enable; input kept for the port map
	logic unusedUnderflow;
	assign unusedUnderflow = underflowEnable & 1'b0;

endmodule : fp_load_address_gen

`default_nettype wire

// ===== verif/fp_load_address_gen_assertions.sv
/* Checker: address, form and write-back relations of the load unit.
   Assumes it is bound onto the top module and sees only its ports. */
`default_nettype none
`include "fp_load_address_gen_defines.svh"
module fp_load_address_gen_assertions #(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// Issue and registers
	input wire logic              issueValid,
	input wire logic [31:0]       issueInstr,
	input wire logic              directStore,
	input wire logic              issueReady,
	input wire logic [ADDR_W-1:0] baseRegVal,
	input wire logic [ADDR_W-1:0] indexRegVal,
	input wire logic              intWrEn,
	input wire logic [4:0]        intWrSel,
	input wire logic [ADDR_W-1:0] intWrData,
	// Memory and results
	input wire logic              memReq,
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic              memDouble,
	input wire logic              memDone,
	input wire logic [63:0]       memData,
	input wire logic              fpWrEn,
	input wire logic [4:0]        fpTarget,
	input wire logic [63:0]       fpWrData,
	input wire logic              invalidForm,
	input wire logic              alignException
);
	logic [5:0]        op;
	logic [9:0]        xo;
	logic              take, dl, xk, xl, upd, dbl, bz, ok, updQ;
	logic [4:0]        tgtQ, selQ;
	logic [ADDR_W-1:0] eaX, eaQ;
	logic [63:0]       memQ;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Decode of the offered word; odd primary codes or xo bit 5 update, bit 1 or 6 means double
	assign op = issueInstr[31:26];
	assign xo = issueInstr[10:1];
	assign take = issueValid && issueReady;
	assign dl = op inside {`OP_SINGLE, `OP_SINGLE_UPD, `OP_DOUBLE, `OP_DOUBLE_UPD};
	assign xk = op == `OP_EXT && xo inside {`XO_SINGLE, `XO_SINGLE_UPD, `XO_DOUBLE, `XO_DOUBLE_UPD};
	assign xl = xk && !issueInstr[0];
	assign upd = dl ? op[0] : xo[5];
	assign dbl = dl ? op[1] : xo[6];
	assign bz = issueInstr[20:16] == 5'h00;
	assign ok = take && (dl || xl) && !(upd && bz) && !directStore;
	assign eaX = ((bz && !upd) ? '0 : baseRegVal)
		+ (dl ? {{(ADDR_W-16){issueInstr[15]}}, issueInstr[15:0]} : indexRegVal);
	// Remember what the accepted load owes at write-back time
	always_ff @(posedge clk) begin
		memQ <= memData;
		if (ok) begin
			updQ <= upd;
			tgtQ <= issueInstr[25:21];
			selQ <= issueInstr[20:16];
			eaQ  <= eaX;
		end
	end
	a_imm_ea_sum: assert property (ok && dl |=> memReq && memAddr == $past(eaX))
		else $error("immediate address wrong");
	a_idx_ea_sum: assert property (ok && xl |=> memReq && memAddr == $past(eaX))
		else $error("indexed address wrong");
	a_load_width: assert property (ok |=> memDouble == $past(dbl))
		else $error("load width wrong");
	a_cond_invalid: assert property (take && xk && issueInstr[0] |=> invalidForm && !memReq)
		else $error("update bit form accepted");
	a_upd_zero_invalid: assert property (take && (dl || xl) && upd && bz |=> invalidForm && !memReq)
		else $error("update with zero base accepted");
	a_dstore_align: assert property (take && (dl || xl) && !(upd && bz) && directStore
		|=> alignException && !memReq)
		else $error("direct-store access performed");
	a_double_raw: assert property (memReq && memDone && memDouble |=> fpWrEn && fpWrData == memQ)
		else $error("double data altered");
	a_single_conv: assert property (memReq && memDone && !memDouble && memData[30:23] != 8'h00
		|=> fpWrEn && fpWrData[63] == memQ[31] && fpWrData[51:0] == {memQ[22:0], 29'h0})
		else $error("single conversion wrong");
	a_target_update: assert property (fpWrEn |-> fpTarget == tgtQ && intWrEn == updQ)
		else $error("target or write-back wrong");
	a_wb_value: assert property (intWrEn |-> intWrSel == selQ && intWrData == eaQ)
		else $error("write-back value wrong");
	// Main scenarios reached
	c_update: cover property (ok && upd);
	c_indexed: cover property (ok && xl);
	c_invalid: cover property (invalidForm);
	c_align: cover property (alignException);
endmodule : fp_load_address_gen_assertions
bind fp_load_address_gen fp_load_address_gen_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ===== verif/fp_mem_model.sv
/* Memory path and integer register file seen from the load unit.
   Assumes memReq stays up until the done pulse. */
`default_nettype none
module fp_mem_model (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Memory path
	input wire logic        memReq,
	output logic            memDone,
	output logic [63:0]     memData,
	// Register reads
	input wire logic [4:0]  baseRegSel,
	input wire logic [4:0]  indexRegSel,
	output logic [31:0]     baseRegVal,
	output logic [31:0]     indexRegVal,
	// Bench controls
	input wire logic [31:0] word,
	input wire logic [3:0]  lat
);
	logic [3:0] cnt;
	// Register contents follow the selector so every read is predictable
	assign baseRegVal = {15'h0, baseRegSel, 12'h000};
	assign indexRegVal = {19'h0, indexRegSel, 8'h00};
	// Answer after lat waits; data is scrambled outside the pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			memDone <= 1'b0;
			memData <= 64'h0;
			cnt     <= 4'h0;
		end else if (memReq && !memDone && cnt == lat) begin
			memDone <= 1'b1;
			memData <= {~word, word};
			cnt     <= 4'h0;
		end else begin
			memDone <= 1'b0;
			memData <= ~memData;
			if (memReq && !memDone)
				cnt <= cnt + 4'h1;
		end
	end
endmodule : fp_mem_model
`default_nettype wire

// ===== verif/fp_load_address_gen_test.sv
/* Self-checking bench for the load unit with its memory partner.
   Assumes the design, package and checker are compiled first. */
`default_nettype none
`include "fp_load_address_gen_defines.svh"
module fp_load_address_gen_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic        issueValid, directStore, underflowEnable, issueReady;
	logic        intWrEn, memReq, memDouble, memDone, fpWrEn, invalidForm, alignException;
	logic        oReq, oUpd, oInv, oAln;
	logic [3:0]  wb_sel_i, lat;
	logic [4:0]  baseRegSel, indexRegSel, intWrSel, fpTarget, oSel, oTgt;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, issueInstr, baseRegVal, indexRegVal;
	logic [31:0] intWrData, memAddr, word, oEa, oWb;
	logic [63:0] memData, fpWrData, oDat;
	int          errors, compares, cycles;
	fp_load_address_gen #(.ADDR_W(32)) u_fp_load_address_gen (.*);
	fp_mem_model u_fp_mem_model (.*);
	always #2 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	// Classic cycle; request held until the edge that sees ack, data taken there
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk);
		while (!wb_ack_o)
			@(posedge clk);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(n, e, q);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	function automatic logic [31:0] dF(logic [5:0] o, logic [4:0] t, b, logic [15:0] d);
		return {o, t, b, d};
	endfunction : dF
	function automatic logic [31:0] xF(logic [9:0] x, logic [4:0] t, b, n, logic c);
		return {`OP_EXT, t, b, n, x, c};
	endfunction : xF
	// Offer one word, then record what the unit does until it finishes
	task automatic issue(input logic [31:0] n, input logic s);
		{oReq, oUpd, oInv, oAln, oDat, oEa, oSel, oWb, oTgt} = '0;
		@(posedge clk);
		issueValid  <= 1'b1;
		issueInstr  <= n;
		directStore <= s;
		// Offer held until the edge that sees ready high
		@(posedge clk);
		while (!issueReady)
			@(posedge clk);
		issueValid <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if (memReq) {oReq, oEa} = {1'b1, memAddr};
			if (intWrEn) {oUpd, oSel, oWb} = {1'b1, intWrSel, intWrData};
			if (fpWrEn) {oDat, oTgt} = {fpWrData, fpTarget};
			oInv |= invalidForm;
			oAln |= alignException;
			if (fpWrEn || oInv || oAln)
				break;
		end
		@(posedge clk);
	endtask : issue
	task automatic look(input logic [31:0] a, input logic [63:0] d, input logic u);
		chk("request", 1'b1, oReq);
		chk("address", a, oEa);
		chk("data", d, oDat);
		chk("update", u, oUpd);
		if (u)
			chk("writeback", a, oWb);
	endtask : look
	task automatic bad(input logic i, input logic a);
		chk("invalid", i, oInv);
		chk("align", a, oAln);
		chk("request", 1'b0, oReq);
	endtask : bad
	////////////////////////////////////////////////////////////////////////
	task automatic tRegs;
		rd(`REG_CTRL, `CTRL_RESET_VAL, "ctrl");
		rd(`REG_STATUS, 32'h0, "status");
		rd(`REG_MASK, 32'h0, "mask");
		wr(8'h14, 32'hffff_ffff);
		rd(8'h14, 32'h0, "unmapped");
	endtask : tRegs
	task automatic tImm;
		word <= 32'h3f80_0000;
		issue(dF(`OP_SINGLE, 5'd9, 5'd3, 16'hfffc), 1'b0);
		look(32'h0000_2ffc, 64'h3ff0_0000_0000_0000, 1'b0);
		chk("target", 5'd9, oTgt);
		word <= 32'h1234_5678;
		issue(dF(`OP_DOUBLE, 5'd2, 5'd0, 16'h0010), 1'b0);
		look(32'h0000_0010, 64'hedcb_a987_1234_5678, 1'b0);
	endtask : tImm
	// Slow memory, underflow enable set: results must not move
	task automatic tIdx;
		underflowEnable <= 1'b1;
		lat <= 4'd3;
		issue(xF(`XO_DOUBLE, 5'd1, 5'd2, 5'd5, 1'b0), 1'b0);
		look(32'h0000_2500, 64'hedcb_a987_1234_5678, 1'b0);
		word <= 32'hc020_0000;
		issue(xF(`XO_SINGLE, 5'd3, 5'd0, 5'd7, 1'b0), 1'b0);
		look(32'h0000_0700, 64'hc004_0000_0000_0000, 1'b0);
		underflowEnable <= 1'b0;
		lat <= 4'd0;
	endtask : tIdx
	task automatic tUpd;
		issue(dF(`OP_SINGLE_UPD, 5'd4, 5'd4, 16'h0008), 1'b0);
		look(32'h0000_4008, 64'hc004_0000_0000_0000, 1'b1);
		chk("wsel", 5'd4, oSel);
		issue(xF(`XO_SINGLE_UPD, 5'd5, 5'd6, 5'd1, 1'b0), 1'b0);
		look(32'h0000_6100, 64'hc004_0000_0000_0000, 1'b1);
		word <= 32'h1234_5678;
		issue(dF(`OP_DOUBLE_UPD, 5'd6, 5'd1, 16'h8000), 1'b0);
		look(32'hffff_9000, 64'hedcb_a987_1234_5678, 1'b1);
		issue(xF(`XO_DOUBLE_UPD, 5'd7, 5'd2, 5'd3, 1'b0), 1'b0);
		look(32'h0000_2300, 64'hedcb_a987_1234_5678, 1'b1);
	endtask : tUpd
	task automatic tBad;
		issue(xF(`XO_SINGLE, 5'd1, 5'd2, 5'd3, 1'b1), 1'b0);
		bad(1'b1, 1'b0);
		issue(dF(`OP_DOUBLE_UPD, 5'd1, 5'd0, 16'h0004), 1'b0);
		bad(1'b1, 1'b0);
		issue(xF(`XO_SINGLE_UPD, 5'd1, 5'd0, 5'd3, 1'b0), 1'b0);
		bad(1'b1, 1'b0);
		issue(dF(`OP_DOUBLE, 5'd1, 5'd2, 16'h0000), 1'b1);
		bad(1'b0, 1'b1);
	endtask : tBad
	// Events, mask, clear-by-one, load count and the enable
	task automatic tIrq;
		rd(`REG_STATUS, 32'h7, "status");
		rd(`REG_COUNT, 32'h8, "count");
		rd(`REG_LAST_EA, 32'h0000_2000, "last address");
		chk("irq", 1'b0, irq);
		wr(`REG_MASK, 32'h2);
		@(negedge clk);
		chk("irq", 1'b1, irq);
		wr(`REG_STATUS, 32'h2);
		@(negedge clk);
		chk("irq", 1'b0, irq);
		rd(`REG_STATUS, 32'h5, "status");
		wr(`REG_COUNT, 32'h0);
		rd(`REG_COUNT, 32'h0, "count");
		wr(`REG_CTRL, 32'h0);
		@(negedge clk);
		chk("ready", 1'b0, issueReady);
		wr(`REG_CTRL, 32'h1);
	endtask : tIrq
	task automatic conclude;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, issueValid, directStore} = '0;
		{underflowEnable, wb_adr_i, wb_dat_i, issueInstr, word, lat} = '0;
		wb_sel_i = 4'hf;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		tRegs();
		tImm();
		tIdx();
		tUpd();
		tBad();
		tIrq();
		conclude();
	end
endmodule : fp_load_address_gen_test
`default_nettype wire
